// ===== verilog/aatr_params.svh
// Constants of the address and trip-range register pair.
// Assumes an I2C slave engine that decodes table, offset and slave byte.
// Notes on behaviour
// - Select bit set: programmed main slave address
// - Programmed A0h disables the auxiliary memory
// - Bits 3:1 set address; spaces differ 10h
// - Read needs upper, or lower with grant
// - Write needs upper, or lower with rw
// - One storage location shared by both spaces
// - Contents kept in nonvolatile shadow memory
// - Upper nibble ranges bias quick trip
// - Bias range default 1.250V, 111b 0.314V
// - Lower nibble ranges power quick trip
// - Power range default 2.507V, 111b 0.629V
// - Bits 7 and 3 reserved, held zero
// - Select clear: fixed A2h and B2h
`ifndef AATR_PARAMS_SVH
`define AATR_PARAMS_SVH

`define AATR_TABLE_SEL        8'h02
`define AATR_OFS_SLAVE_ADDR   8'h8B
`define AATR_OFS_TRIP_SCALE   8'h8C
`define AATR_RST_SLAVE_ADDR   8'h00
`define AATR_RST_TRIP_SCALE   8'h00
`define AATR_FIXED_TX1        8'hA2
`define AATR_FIXED_TX2        8'hB2
`define AATR_AUX_OFF_ADDR     8'hA0
`define AATR_TX1_NIBBLE       4'hA
`define AATR_TX2_NIBBLE       4'hB
`define AATR_TRIP_WMASK       8'h77
`define AATR_BIAS_MSB         6
`define AATR_BIAS_LSB         4
`define AATR_POWER_MSB        2
`define AATR_POWER_LSB        0
`define AATR_ADDR_MSB         3
`define AATR_ADDR_LSB         1

// Full-scale comparison voltages in millivolts
`define AATR_BIAS_MV_0        12'h4E2
`define AATR_BIAS_MV_1        12'h3E8
`define AATR_BIAS_MV_2        12'h342
`define AATR_BIAS_MV_3        12'h272
`define AATR_BIAS_MV_4        12'h1F5
`define AATR_BIAS_MV_5        12'h1A2
`define AATR_BIAS_MV_6        12'h166
`define AATR_BIAS_MV_7        12'h13A
`define AATR_POWER_MV_0       12'h9CB
`define AATR_POWER_MV_1       12'h7D6
`define AATR_POWER_MV_2       12'h688
`define AATR_POWER_MV_3       12'h4E7
`define AATR_POWER_MV_4       12'h3ED
`define AATR_POWER_MV_5       12'h346
`define AATR_POWER_MV_6       12'h2CE
`define AATR_POWER_MV_7       12'h275

`endif

// ===== verilog/aatr_pkg.sv
// Types shared by the address and trip-range register pair.
// Assumes nothing of its surroundings.
package aatr_pkg;
    typedef logic [7:0]  aatr_byte_type;
    typedef logic [2:0]  aatr_range_type;
    typedef logic [11:0] aatr_mv_type;
endpackage

// ===== verilog/aatr_regs.sv
// Main slave address and transmitter 2 quick-trip range registers.
// Assumes an I2C slave engine presenting one access per strobe and
// a nonvolatile store that replays saved bytes after power-up.
`timescale 1ns/1ps
`include "aatr_params.svh"

module aatr_regs (
    input  wire logic               i_clock,
    input  wire logic               i_nrst,
    input  wire logic               i_clock_en,
    input  wire logic               i_main_address_select,
    input  wire logic               i_upper_password_level,
    input  wire logic               i_lower_password_level,
    input  wire logic               i_table_read_write_grant,
    input  wire logic               i_table_read_grant,
    input  wire aatr_pkg::aatr_byte_type i_slave_addr,
    input  wire aatr_pkg::aatr_byte_type i_table_sel,
    input  wire aatr_pkg::aatr_byte_type i_reg_offset,
    input  wire logic               i_wr_en,
    input  wire logic               i_rd_en,
    input  wire aatr_pkg::aatr_byte_type i_wr_data,
    input  wire logic               i_nv_restore_en,
    input  wire aatr_pkg::aatr_byte_type i_nv_restore_offset,
    input  wire aatr_pkg::aatr_byte_type i_nv_restore_data,
    output logic                    o_rd_valid,
    output aatr_pkg::aatr_byte_type o_rd_data,
    output logic                    o_access_denied,
    output logic                    o_nv_wr_en,
    output aatr_pkg::aatr_byte_type o_nv_wr_offset,
    output aatr_pkg::aatr_byte_type o_nv_wr_data,
    output aatr_pkg::aatr_byte_type o_main_addr_tx1,
    output aatr_pkg::aatr_byte_type o_main_addr_tx2,
    output logic                    o_aux_mem_enable,
    output aatr_pkg::aatr_range_type o_bias_trip_range_tx2,
    output aatr_pkg::aatr_range_type o_power_trip_range_tx2,
    output aatr_pkg::aatr_mv_type   o_bias_full_scale_mv,
    output aatr_pkg::aatr_mv_type   o_power_full_scale_mv
);

    aatr_pkg::aatr_byte_type addr_reg;
    aatr_pkg::aatr_byte_type addr_next;
    aatr_pkg::aatr_byte_type trip_reg;
    aatr_pkg::aatr_byte_type trip_next;
    aatr_pkg::aatr_byte_type tx1_next;
    aatr_pkg::aatr_byte_type tx2_next;
    aatr_pkg::aatr_byte_type rd_value;
    aatr_pkg::aatr_byte_type nv_data_next;
    aatr_pkg::aatr_range_type bias_next;
    aatr_pkg::aatr_range_type power_next;
    logic [2:0] prog_bits;
    logic space_hit;
    logic sel_addr;
    logic sel_trip;
    logic sel_any;
    logic rd_ok;
    logic wr_ok;
    logic wr_addr;
    logic wr_trip;
    logic wr_any;
    logic rd_req;
    logic denied;
    logic rst_addr;
    logic rst_trip;

    function automatic aatr_pkg::aatr_mv_type bias_mv(
        input aatr_pkg::aatr_range_type code);
        case (code)
            3'h0:    bias_mv = `AATR_BIAS_MV_0;
            3'h1:    bias_mv = `AATR_BIAS_MV_1;
            3'h2:    bias_mv = `AATR_BIAS_MV_2;
            3'h3:    bias_mv = `AATR_BIAS_MV_3;
            3'h4:    bias_mv = `AATR_BIAS_MV_4;
            3'h5:    bias_mv = `AATR_BIAS_MV_5;
            3'h6:    bias_mv = `AATR_BIAS_MV_6;
            default: bias_mv = `AATR_BIAS_MV_7;
        endcase
    endfunction

    function automatic aatr_pkg::aatr_mv_type power_mv(
        input aatr_pkg::aatr_range_type code);
        case (code)
            3'h0:    power_mv = `AATR_POWER_MV_0;
            3'h1:    power_mv = `AATR_POWER_MV_1;
            3'h2:    power_mv = `AATR_POWER_MV_2;
            3'h3:    power_mv = `AATR_POWER_MV_3;
            3'h4:    power_mv = `AATR_POWER_MV_4;
            3'h5:    power_mv = `AATR_POWER_MV_5;
            3'h6:    power_mv = `AATR_POWER_MV_6;
            default: power_mv = `AATR_POWER_MV_7;
        endcase
    endfunction

    // either space reaches
    // Decode uses the address now in force, so a rename of the main
    // address takes effect from the access after the write.
    assign space_hit = (i_table_sel == `AATR_TABLE_SEL) &&
                       ((i_slave_addr[7:1] == o_main_addr_tx1[7:1]) ||
                        (i_slave_addr[7:1] == o_main_addr_tx2[7:1]));
    assign sel_addr = space_hit && (i_reg_offset == `AATR_OFS_SLAVE_ADDR);
    assign sel_trip = space_hit && (i_reg_offset == `AATR_OFS_TRIP_SCALE);
    assign sel_any  = sel_addr || sel_trip;

    assign rd_ok = i_upper_password_level ||
                   (i_lower_password_level &&
                    (i_table_read_write_grant || i_table_read_grant));
    assign wr_ok = i_upper_password_level ||
                   (i_lower_password_level && i_table_read_write_grant);

    assign wr_addr = i_wr_en && sel_addr && wr_ok;
    assign wr_trip = i_wr_en && sel_trip && wr_ok;
    assign wr_any  = wr_addr || wr_trip;
    assign rd_req  = i_rd_en && !i_wr_en && sel_any;
    assign denied  = (i_wr_en && sel_any && !wr_ok) ||
                     (rd_req && !rd_ok);

    assign rst_addr = i_nv_restore_en &&
                      (i_nv_restore_offset == `AATR_OFS_SLAVE_ADDR);
    assign rst_trip = i_nv_restore_en &&
                      (i_nv_restore_offset == `AATR_OFS_TRIP_SCALE);

    // denied write holds
    // A bus write outranks a replay arriving in the same cycle.
    assign addr_next = wr_addr  ? i_wr_data :
                       rst_addr ? i_nv_restore_data : addr_reg;
    assign trip_next = wr_trip  ? (i_wr_data & `AATR_TRIP_WMASK) :
                       rst_trip ? (i_nv_restore_data & `AATR_TRIP_WMASK) :
                       trip_reg;

    assign prog_bits = addr_next[`AATR_ADDR_MSB:`AATR_ADDR_LSB];
    assign tx1_next = i_main_address_select ?
                      {`AATR_TX1_NIBBLE, prog_bits, 1'b0} : `AATR_FIXED_TX1;
    assign tx2_next = i_main_address_select ?
                      {`AATR_TX2_NIBBLE, prog_bits, 1'b0} : `AATR_FIXED_TX2;

    assign bias_next  = trip_next[`AATR_BIAS_MSB:`AATR_BIAS_LSB];
    assign power_next = trip_next[`AATR_POWER_MSB:`AATR_POWER_LSB];

    assign rd_value = !rd_ok   ? 8'h00 :
                      sel_addr ? addr_reg : trip_reg;
    assign nv_data_next = wr_addr ? i_wr_data
                                  : (i_wr_data & `AATR_TRIP_WMASK);

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_reg <= `AATR_RST_SLAVE_ADDR;
            trip_reg <= `AATR_RST_TRIP_SCALE;
        end else if (i_clock_en) begin
            addr_reg <= addr_next;
            trip_reg <= trip_next;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_main_addr_tx1  <= `AATR_FIXED_TX1;
            o_main_addr_tx2  <= `AATR_FIXED_TX2;
            o_aux_mem_enable <= 1'b1;
        end else if (i_clock_en) begin
            o_main_addr_tx1  <= tx1_next;
            o_main_addr_tx2  <= tx2_next;
            o_aux_mem_enable <= (addr_next != `AATR_AUX_OFF_ADDR);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bias_trip_range_tx2  <= 3'h0;
            o_power_trip_range_tx2 <= 3'h0;
            o_bias_full_scale_mv   <= `AATR_BIAS_MV_0;
            o_power_full_scale_mv  <= `AATR_POWER_MV_0;
        end else if (i_clock_en) begin
            o_bias_trip_range_tx2  <= bias_next;
            o_power_trip_range_tx2 <= power_next;
            o_bias_full_scale_mv   <= bias_mv(bias_next);
            o_power_full_scale_mv  <= power_mv(power_next);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rd_valid      <= 1'b0;
            o_rd_data       <= 8'h00;
            o_access_denied <= 1'b0;
        end else if (i_clock_en) begin
            o_rd_valid      <= rd_req;
            o_rd_data       <= rd_req ? rd_value : 8'h00;
            o_access_denied <= denied;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_nv_wr_en     <= 1'b0;
            o_nv_wr_offset <= 8'h00;
            o_nv_wr_data   <= 8'h00;
        end else if (i_clock_en) begin
            o_nv_wr_en     <= wr_any;
            o_nv_wr_offset <= wr_any ? i_reg_offset : 8'h00;
            o_nv_wr_data   <= wr_any ? nv_data_next : 8'h00;
        end
    end

    logic sel_addr_q;

    default clocking aatr_cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    sequence s_granted_write;
        i_clock_en && wr_any;
    endsequence

    sequence s_refused_write;
        i_clock_en && i_wr_en && sel_any && !wr_ok && !i_nv_restore_en;
    endsequence

    sequence s_stored_copy;
        o_nv_wr_en && (o_nv_wr_data == (sel_addr_q ? addr_reg : trip_reg));
    endsequence

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_addr_q <= 1'b0;
        end else if (i_clock_en) begin
            sel_addr_q <= wr_addr;
        end
    end

    fixed_addr_a: assert property (
        i_clock_en && !i_main_address_select |=>
        o_main_addr_tx1 == 8'hA2 && o_main_addr_tx2 == 8'hB2)
        else $error("fixed main address wrong");

    prog_addr_a: assert property (
        i_clock_en && i_main_address_select |=>
        o_main_addr_tx1 == {4'hA, addr_reg[3:1], 1'b0})
        else $error("programmed main address wrong");

    addr_spacing_a: assert property (
        i_clock_en && i_main_address_select |=>
        o_main_addr_tx2 == o_main_addr_tx1 + 8'h10)
        else $error("address spaces not 10h apart");

    aux_disable_a: assert property (
        i_clock_en |=> o_aux_mem_enable == (addr_reg != 8'hA0))
        else $error("auxiliary enable wrong");

    read_gate_a: assert property (
        i_clock_en && rd_req && !rd_ok |=>
        o_rd_valid && o_rd_data == 8'h00 && o_access_denied)
        else $error("ungranted read leaked data");

    write_gate_a: assert property (
        s_refused_write |=> $stable(addr_reg) && $stable(trip_reg))
        else $error("ungranted write changed data");

    shared_store_a: assert property (
        s_granted_write ##0 wr_trip |=>
        trip_reg == ($past(i_wr_data) & 8'h77))
        else $error("shared write not stored");

    nv_copy_a: assert property (
        s_granted_write |=> s_stored_copy)
        else $error("accepted write not sent to shadow");

    reserved_zero_a: assert property (
        trip_reg[7] == 1'b0 && trip_reg[3] == 1'b0)
        else $error("reserved range bit set");

    bias_scale_a: assert property (
        i_clock_en |=> (trip_reg[6:4] != 3'h0 ||
        o_bias_full_scale_mv == 12'h4E2) && (trip_reg[6:4] != 3'h7 ||
        o_bias_full_scale_mv == 12'h13A))
        else $error("bias full scale wrong");

    power_scale_a: assert property (
        i_clock_en |=> (trip_reg[2:0] != 3'h0 ||
        o_power_full_scale_mv == 12'h9CB) && (trip_reg[2:0] != 3'h7 ||
        o_power_full_scale_mv == 12'h275))
        else $error("power full scale wrong");

    range_out_a: assert property (
        i_clock_en |=> o_bias_trip_range_tx2 == trip_reg[6:4] &&
        o_power_trip_range_tx2 == trip_reg[2:0])
        else $error("range outputs differ from register");

    freeze_a: assert property (
        !i_clock_en |=> $stable(addr_reg) && $stable(o_rd_valid))
        else $error("state moved with clock enable low");

endmodule

// ===== dv/aatr_host_model.sv
// Host side model: the I2C slave engine that hands one access a strobe.
// Assumes the register pair answers on the taking edge, ready 1 ns after it.
`timescale 1ns/1ps

module aatr_host_model (
    input  wire logic                    i_clock,
    input  wire logic                    i_rd_valid,
    input  wire aatr_pkg::aatr_byte_type i_rd_data,
    input  wire logic                    i_access_denied,
    input  wire logic                    i_nv_wr_en,
    input  wire aatr_pkg::aatr_byte_type i_nv_wr_data,
    output logic                         o_wr_en,
    output logic                         o_rd_en,
    output aatr_pkg::aatr_byte_type      o_slave_addr,
    output aatr_pkg::aatr_byte_type      o_table_sel,
    output aatr_pkg::aatr_byte_type      o_reg_offset,
    output aatr_pkg::aatr_byte_type      o_wr_data
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_slave_addr = 8'h00;
        o_table_sel = 8'h02;
        o_reg_offset = 8'h00;
        o_wr_data = 8'h00;
    end

    // Released strobes drop low; slave address, offset and data flip to the inverse so stale values never look valid
    task automatic access(input logic wr, input aatr_pkg::aatr_byte_type a,
                          input aatr_pkg::aatr_byte_type o, d,
                          output aatr_pkg::aatr_byte_type res,
                          output logic v, dn, nv);
        @(posedge i_clock);
        #1;
        o_wr_en = wr;
        o_rd_en = ~wr;
        o_slave_addr = a;
        o_reg_offset = o;
        o_wr_data = d;
        @(posedge i_clock);
        #1;
        res = wr ? i_nv_wr_data : i_rd_data;
        v = i_rd_valid;
        dn = i_access_denied;
        nv = i_nv_wr_en;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_slave_addr = ~o_slave_addr;
        o_reg_offset = ~o_reg_offset;
        o_wr_data = ~o_wr_data;
    endtask
endmodule

// ===== dv/aatr_regs_tb_top.sv
// Self-checking bench of the address and trip-range register pair.
// Assumes the host model drives the access strobes.
`timescale 1ns/1ps

`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("[FAIL] %0t got %h want %h", $time, (g), (e)); \
    end \
end

module aatr_regs_tb_top;
    typedef struct packed {
        logic [3:0] pw;
        logic       wr;
        logic [7:0] a, o, d;
        logic [2:0] ex;
        logic [7:0] eb;
    } aatr_row_type;
    logic clk = 1'b0, nrst = 1'b0, sel = 1'b0, nv_en = 1'b0;
    logic ce = 1'b1;
    logic up = 1'b0, lo = 1'b0, rw = 1'b0, rg = 1'b0;
    logic wr_en, rd_en, rd_v, den, nvw, aux, v, dn, nv;
    aatr_pkg::aatr_byte_type  nv_ofs = 8'h00, nv_dat = 8'h00;
    aatr_pkg::aatr_byte_type  sa, ts, ofs, wd, rdd, nvo, nvd, t1, t2, b;
    aatr_pkg::aatr_range_type br, pr;
    aatr_pkg::aatr_mv_type    bmv, pmv;
    aatr_pkg::aatr_mv_type    bias_mv[8] = '{12'h4E2, 12'h3E8, 12'h342,
        12'h272, 12'h1F5, 12'h1A2, 12'h166, 12'h13A};
    aatr_pkg::aatr_mv_type    pow_mv[8] = '{12'h9CB, 12'h7D6, 12'h688,
        12'h4E7, 12'h3ED, 12'h346, 12'h2CE, 12'h275};
    aatr_row_type rows[11] = '{
        '{4'h8, 1'b1, 8'hA2, 8'h8C, 8'hFF, 3'b001, 8'h77},
        '{4'h5, 1'b0, 8'hB2, 8'h8C, 8'h00, 3'b100, 8'h77},
        '{4'h4, 1'b0, 8'hA2, 8'h8C, 8'h00, 3'b110, 8'h00},
        '{4'h4, 1'b1, 8'hA2, 8'h8C, 8'h12, 3'b010, 8'h00},
        '{4'h5, 1'b1, 8'hA2, 8'h8C, 8'h12, 3'b010, 8'h00},
        '{4'h2, 1'b1, 8'hA2, 8'h8C, 8'h11, 3'b010, 8'h00},
        '{4'h6, 1'b1, 8'hB2, 8'h8C, 8'h25, 3'b001, 8'h25},
        '{4'h8, 1'b0, 8'hA2, 8'h8C, 8'h00, 3'b100, 8'h25},
        '{4'h6, 1'b0, 8'hA2, 8'h8B, 8'h00, 3'b100, 8'h00},
        '{4'h0, 1'b0, 8'hA2, 8'h8B, 8'h00, 3'b110, 8'h00},
        '{4'h8, 1'b0, 8'hA2, 8'h8D, 8'h00, 3'b000, 8'h00}};
    int bad_count = 0, n_compared = 0;

    always #20 clk = ~clk;

    aatr_host_model u_host (.i_clock(clk), .i_rd_valid(rd_v),
        .i_rd_data(rdd), .i_access_denied(den), .i_nv_wr_en(nvw),
        .i_nv_wr_data(nvd), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_slave_addr(sa), .o_table_sel(ts), .o_reg_offset(ofs),
        .o_wr_data(wd));

    aatr_regs u_dut (.i_clock(clk), .i_nrst(nrst), .i_clock_en(ce),
        .i_main_address_select(sel), .i_upper_password_level(up),
        .i_lower_password_level(lo), .i_table_read_write_grant(rw),
        .i_table_read_grant(rg), .i_slave_addr(sa), .i_table_sel(ts),
        .i_reg_offset(ofs), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_wr_data(wd), .i_nv_restore_en(nv_en),
        .i_nv_restore_offset(nv_ofs), .i_nv_restore_data(nv_dat),
        .o_rd_valid(rd_v), .o_rd_data(rdd), .o_access_denied(den),
        .o_nv_wr_en(nvw), .o_nv_wr_offset(nvo), .o_nv_wr_data(nvd),
        .o_main_addr_tx1(t1), .o_main_addr_tx2(t2),
        .o_aux_mem_enable(aux), .o_bias_trip_range_tx2(br),
        .o_power_trip_range_tx2(pr), .o_bias_full_scale_mv(bmv),
        .o_power_full_scale_mv(pmv));

    task tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Replay bypasses passwords, like the store reload after power-up
    task replay(input aatr_pkg::aatr_byte_type o, d);
        nv_ofs = o;
        nv_dat = d;
        nv_en = 1'b1;
        @(posedge clk);
        #1;
        nv_en = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1;
        `CHK({t1, t2, aux}, {8'hA2, 8'hB2, 1'b1})
        `CHK({br, pr, bmv, pmv}, {6'h00, 12'h4E2, 12'h9CB})
        nrst = 1'b1;
        foreach (rows[i]) begin
            {up, lo, rw, rg} = rows[i].pw;
            u_host.access(rows[i].wr, rows[i].a, rows[i].o, rows[i].d,
                          b, v, dn, nv);
            `CHK({v, dn, nv}, rows[i].ex)
            `CHK(b, rows[i].eb)
        end
        {up, lo, rw, rg} = 4'h8;
        for (int i = 0; i < 8; i++) begin
            u_host.access(1'b1, 8'hA2, 8'h8C,
                          {1'b1, i[2:0], 1'b1, ~i[2:0]}, b, v, dn, nv);
            `CHK(b, {1'b0, i[2:0], 1'b0, ~i[2:0]})
            `CHK({br, pr}, {i[2:0], ~i[2:0]})
            `CHK(bmv, bias_mv[i])
            `CHK(pmv, pow_mv[7 - i])
        end
        u_host.access(1'b1, 8'hB2, 8'h8B, 8'h05, b, v, dn, nv);
        `CHK({nv, nvo, b}, {1'b1, 8'h8B, 8'h05})
        sel = 1'b1;
        settle();
        `CHK({t1, t2}, {8'hA4, 8'hB4})
        u_host.access(1'b0, 8'hB4, 8'h8B, 8'h00, b, v, dn, nv);
        `CHK(b, 8'h05)
        u_host.access(1'b0, 8'hA2, 8'h8B, 8'h00, b, v, dn, nv);
        `CHK({v, dn}, 2'b00)
        u_host.access(1'b1, 8'hA4, 8'h8B, 8'hA0, b, v, dn, nv);
        settle();
        `CHK(aux, 1'b0)
        sel = 1'b0;
        settle();
        `CHK({t1, t2, aux}, {8'hA2, 8'hB2, 1'b0})
        replay(8'h8B, 8'h00);
        `CHK(aux, 1'b1)
        replay(8'h8C, 8'hFF);
        u_host.access(1'b0, 8'hB2, 8'h8C, 8'h00, b, v, dn, nv);
        `CHK(b, 8'h77)
        // Clock enable low: a granted write must not be taken
        ce = 1'b0;
        u_host.access(1'b1, 8'hA2, 8'h8C, 8'h11, b, v, dn, nv);
        `CHK({nv, br}, {1'b0, 3'h7})
        ce = 1'b1;
        u_host.access(1'b0, 8'hB2, 8'h8C, 8'h00, b, v, dn, nv);
        `CHK(b, 8'h77)
        // Mid-run reset must drop back to defaults at once
        nrst = 1'b0;
        #2;
        `CHK({br, pr, bmv, pmv}, {6'h00, 12'h4E2, 12'h9CB})
        nrst = 1'b1;
        u_host.access(1'b0, 8'hA2, 8'h8C, 8'h00, b, v, dn, nv);
        `CHK({v, b, t1, aux}, {1'b1, 8'h00, 8'hA2, 1'b1})
        tally_and_finish();
    end

    initial begin
        #2000000;
        bad_count++;
        tally_and_finish();
    end
endmodule
